// *** src/ivm_defs.vh ***
// constants for the interrupt vector mapping block
// assumes a single system clock and an active-low asynchronous reset
// Functional notes
// - every vector belongs to exactly one peripheral instance; sources may share vectors
// - a flag is set on its condition even while its enable is clear
// - a source requests only while its enable and its flag are both set
// - no request other than the nmi reaches the core unless the global enable is set
// - a request stays pending until software clears the flag
// - vector 1 at word 0x02 is the non-maskable interrupt; vector 0 is reset
// - vector 2 at word 0x04 is the voltage level monitor
// - vector 3 at word 0x06 is the clock failure detector
// - vector 5 at word 0x0A is the rtc overflow or compare
// - vector 6 at word 0x0C is the rtc periodic interrupt
// - vector 7 at word 0x0E is the custom logic interrupt
// - vector 9 at 0x12 is timer A overflow, or low underflow in split mode
// - vector 10 at 0x14 is unused normally, high underflow in split mode
// - vectors 11 to 13 serve timer A compare 0 to 2, low compares when split
// - vectors 14 and 15 serve timer B instances 0 and 1
// - vectors 16 and 17 serve timer D overflow and trigger
// - vectors 18 and 19 serve two-wire client and host
// - vector 20 at 0x28 serves the serial peripheral interface
// - vectors 21 to 23 serve serial0 receive, data empty, transmit done
// - vectors 26 and 27 serve converter result ready and window compare
`ifndef IVM_DEFS_VH
`define IVM_DEFS_VH
`define IVM_NUM_VEC 30
`define IVM_VEC_W 5
`define IVM_ADDR_W 6
`define IVM_VEC_RESET 5'h00
`define IVM_VEC_NMI 5'h01
`define IVM_VEC_VLM 5'h02
`define IVM_VEC_CFD 5'h03
`define IVM_VEC_MVIO 5'h04
`define IVM_VEC_RTC_OVERFLOW_COMPARE_IRQ 5'h05
`define IVM_VEC_RTC_PERIODIC_IRQ 5'h06
`define IVM_VEC_CUSTOM 5'h07
`define IVM_VEC_PORT_A 5'h08
`define IVM_VEC_TA_OVF 5'h09
`define IVM_VEC_TA_HUNF 5'h0A
`define IVM_VEC_TA_CMP0 5'h0B
`define IVM_VEC_TA_CMP1 5'h0C
`define IVM_VEC_TA_CMP2 5'h0D
`define IVM_VEC_TB0 5'h0E
`define IVM_VEC_TB1 5'h0F
`define IVM_VEC_TD_OVF 5'h10
`define IVM_VEC_TD_TRIG 5'h11
`define IVM_VEC_TW_CLIENT 5'h12
`define IVM_VEC_TW_HOST 5'h13
`define IVM_VEC_SPI 5'h14
`define IVM_VEC_S0_RXC 5'h15
`define IVM_VEC_S0_DRE 5'h16
`define IVM_VEC_S0_TXC 5'h17
`define IVM_VEC_PORT_D 5'h18
`define IVM_VEC_COMP 5'h19
`define IVM_VEC_ADC_RDY 5'h1A
`define IVM_VEC_ADC_WIN 5'h1B
`define IVM_VEC_ZCD 5'h1C
`define IVM_VEC_PORT_C 5'h1D
`endif

// *** src/ivm_source_cell.v ***
// one interrupt source: sticky flag, enable gate
// assumes set and clear pulses come from logic on the same clock
`default_nettype none
module ivm_source_cell (
  // clock and reset
  input wire clk_in,
  input wire rst_b_in,
  // source side
  input wire cond_in,
  input wire clear_in,
  input wire enable_in,
  // status
  output wire flag_out,
  output wire req_out
);
  reg flag_q;
  // set wins over clear so no event is lost
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flag_q <= 1'b0;
    end else if (cond_in) begin
      flag_q <= 1'b1;
    end else if (clear_in) begin
      flag_q <= 1'b0;
    end
  end
  assign flag_out = flag_q;
  assign req_out = flag_q & enable_in;
endmodule // ivm_source_cell
`default_nettype wire

// *** src/ivm_vector_encoder.v ***
// picks the lowest pending vector number and its word address
// assumes requests already gated by enables
`default_nettype none
`include "ivm_defs.vh"
module ivm_vector_encoder (
  // pending vectors
  input wire [`IVM_NUM_VEC-1:0] pend_in,
  // result
  output reg any_out,
  output reg [`IVM_VEC_W-1:0] vec_out,
  output reg [`IVM_ADDR_W-1:0] addr_out
);
  integer i;
  // each vector takes two program words
  function [`IVM_ADDR_W-1:0] word_addr;
    input [`IVM_VEC_W-1:0] v;
    begin
      word_addr = {v, 1'b0};
    end
  endfunction
  always @* begin
    any_out = 1'b0;
    vec_out = 5'h00;
    for (i = `IVM_NUM_VEC - 1; i > 0; i = i - 1) begin
      if (pend_in[i]) begin
        any_out = 1'b1;
        vec_out = i[`IVM_VEC_W-1:0];
      end
    end
    addr_out = word_addr(vec_out);
  end
endmodule // ivm_vector_encoder
`default_nettype wire

// *** src/ivm_top.v ***
// interrupt vector mapping: peripheral flags to one vectored core request
// assumes event and clear pulses arrive from same-clock peripheral logic
`default_nettype none
`include "ivm_defs.vh"
module ivm_top (
  // clock and reset
  input wire MCLK_IN,
  input wire RST_B_IN,
  // global control
  input wire GLOBAL_EN_IN,
  input wire TIMER_A_SPLIT_IN,
  input wire NMI_IN,
  // per-source events, indexed by vector slot
  input wire [`IVM_NUM_VEC-1:0] EVENT_IN,
  // per-source flag clears from software
  input wire [`IVM_NUM_VEC-1:0] CLEAR_IN,
  // per-source enable bits from control registers
  input wire [`IVM_NUM_VEC-1:0] ENABLE_IN,
  // flags back to peripherals
  output reg [`IVM_NUM_VEC-1:0] FLAGS_OUT,
  // core request
  output reg IRQ_OUT,
  output reg NMI_REQ_OUT,
  output reg [`IVM_VEC_W-1:0] VECTOR_OUT,
  output reg [`IVM_ADDR_W-1:0] VEC_ADDR_OUT
);

  // ************************************
  // source slots
  // ************************************
  wire [`IVM_NUM_VEC-1:0] flag;
  wire [`IVM_NUM_VEC-1:0] req;
  reg [`IVM_NUM_VEC-1:0] slot_used;
  reg [`IVM_NUM_VEC-1:0] cond;
  reg [`IVM_NUM_VEC-1:0] pend;
  integer k;

  // ************************************
  // slot decode
  // ************************************
  // one entry per vector; reset and nmi own no flag slot
  function slot_exists;
    input [`IVM_VEC_W-1:0] v;
    input split;
    begin
      case (v)
        `IVM_VEC_RESET: begin
          slot_exists = 1'b0;
        end
        `IVM_VEC_NMI: begin
          slot_exists = 1'b0;
        end
        `IVM_VEC_VLM: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_CFD: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_MVIO: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_RTC_OVERFLOW_COMPARE_IRQ: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_RTC_PERIODIC_IRQ: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_CUSTOM: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_PORT_A: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_TA_OVF: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_TA_HUNF: begin
          slot_exists = split;
        end
        `IVM_VEC_TA_CMP0: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_TA_CMP1: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_TA_CMP2: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_TB0: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_TB1: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_TD_OVF: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_TD_TRIG: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_TW_CLIENT: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_TW_HOST: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_SPI: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_S0_RXC: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_S0_DRE: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_S0_TXC: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_PORT_D: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_COMP: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_ADC_RDY: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_ADC_WIN: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_ZCD: begin
          slot_exists = 1'b1;
        end
        `IVM_VEC_PORT_C: begin
          slot_exists = 1'b1;
        end
        default: begin
          slot_exists = 1'b0;
        end
      endcase
    end
  endfunction

  // which slots exist; slot 10 only while timer A is split
  always @* begin
    for (k = 0; k < `IVM_NUM_VEC; k = k + 1) begin
      slot_used[k] = slot_exists(k[`IVM_VEC_W-1:0], TIMER_A_SPLIT_IN);
    end
  end

  always @* begin
    for (k = 0; k < `IVM_NUM_VEC; k = k + 1) begin
      cond[k] = EVENT_IN[k] & slot_used[k];
    end
  end

  genvar g;
  generate
    for (g = 0; g < `IVM_NUM_VEC; g = g + 1) begin : g_src
      ivm_source_cell u_cell (
        .clk_in(MCLK_IN),
        .rst_b_in(RST_B_IN),
        .cond_in(cond[g]),
        .clear_in(CLEAR_IN[g]),
        .enable_in(ENABLE_IN[g]),
        .flag_out(flag[g]),
        .req_out(req[g])
      );
    end
  endgenerate

  // ************************************
  // global gate and encoding
  // ************************************
  always @* begin
    pend = req & slot_used & {`IVM_NUM_VEC{GLOBAL_EN_IN}};
  end

  wire any_pend;
  wire [`IVM_VEC_W-1:0] enc_vec;
  wire [`IVM_ADDR_W-1:0] enc_addr;
  ivm_vector_encoder u_enc (
    .pend_in(pend),
    .any_out(any_pend),
    .vec_out(enc_vec),
    .addr_out(enc_addr)
  );

  // ************************************
  // registered outputs
  // ************************************
  always @(posedge MCLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      FLAGS_OUT <= {`IVM_NUM_VEC{1'b0}};
      IRQ_OUT <= 1'b0;
      NMI_REQ_OUT <= 1'b0;
      VECTOR_OUT <= `IVM_VEC_RESET;
      VEC_ADDR_OUT <= 6'h00;
    end else begin
      FLAGS_OUT <= flag;
      NMI_REQ_OUT <= NMI_IN;
      if (NMI_IN) begin
        IRQ_OUT <= 1'b1;
        VECTOR_OUT <= `IVM_VEC_NMI;
        VEC_ADDR_OUT <= {`IVM_VEC_NMI, 1'b0};
      end else begin
        IRQ_OUT <= any_pend;
        VECTOR_OUT <= enc_vec;
        VEC_ADDR_OUT <= enc_addr;
      end
    end
  end

endmodule // ivm_top
`default_nettype wire

// *** test/ivm_props_properties.sv ***
// port assertions for the vector mapping top
// assumes one clock and its active-low reset
`default_nettype none
`include "ivm_defs.vh"
module ivm_props (
  // clock and reset
  input wire logic MCLK_IN,
  input wire logic RST_B_IN,
  // control
  input wire logic GLOBAL_EN_IN,
  input wire logic TIMER_A_SPLIT_IN,
  input wire logic NMI_IN,
  // per-source vectors
  input wire logic [`IVM_NUM_VEC-1:0] EVENT_IN,
  input wire logic [`IVM_NUM_VEC-1:0] CLEAR_IN,
  input wire logic [`IVM_NUM_VEC-1:0] ENABLE_IN,
  input wire logic [`IVM_NUM_VEC-1:0] FLAGS_OUT,
  // core request
  input wire logic IRQ_OUT,
  input wire logic NMI_REQ_OUT,
  input wire logic [`IVM_VEC_W-1:0] VECTOR_OUT,
  input wire logic [`IVM_ADDR_W-1:0] VEC_ADDR_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RST_B_IN);
  sequence s_calm;
    (CLEAR_IN == 30'h0 && $stable(ENABLE_IN) && GLOBAL_EN_IN && !NMI_IN)[*3];
  endsequence
  property p_addr; VEC_ADDR_OUT == {VECTOR_OUT, 1'b0}; endproperty
  property p_rsv; FLAGS_OUT[1:0] == 2'h0; endproperty
  property p_set; EVENT_IN[5] |-> ##[1:2] FLAGS_OUT[5]; endproperty
  property p_nmi; NMI_IN |-> ##[1:2] (NMI_REQ_OUT && IRQ_OUT && VECTOR_OUT == 5'h01); endproperty
  property p_hunf;
    $rose(FLAGS_OUT[10]) |-> $past(TIMER_A_SPLIT_IN) || $past(TIMER_A_SPLIT_IN, 2);
  endproperty
  property p_hold; s_calm ##0 IRQ_OUT |=> IRQ_OUT; endproperty
  property p_gmask; (!GLOBAL_EN_IN && !NMI_IN)[*3] |-> !IRQ_OUT; endproperty
  property p_emask; (ENABLE_IN == 30'h0 && !NMI_IN)[*3] |-> !IRQ_OUT; endproperty
  a_addr: assert property (p_addr)
    else $error("bad address");
  a_rsv: assert property (p_rsv)
    else $error("flag in slot 0 or 1");
  a_set: assert property (p_set)
    else $error("flag not set");
  a_nmi: assert property (p_nmi)
    else $error("nmi not presented");
  a_hunf: assert property (p_hunf)
    else $error("slot 10 set in normal mode");
  a_hold: assert property (p_hold)
    else $error("request dropped");
  a_gmask: assert property (p_gmask)
    else $error("request while globally off");
  a_emask: assert property (p_emask)
    else $error("request while disabled");
endmodule // ivm_props
`default_nettype wire

// *** test/ivm_core_model.sv ***
// core model: services the presented vector by clearing its flag
// assumes inputs change at the falling edge
`default_nettype none
`include "ivm_defs.vh"
module ivm_core_model (
  input wire logic clk_in,
  input wire logic serve_in,
  input wire logic irq_in,
  input wire logic [`IVM_VEC_W-1:0] vec_in,
  output logic [`IVM_NUM_VEC-1:0] clear_out = 30'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(negedge clk_in) begin
    clear_out <= (serve_in && irq_in) ? (30'h1 << vec_in) : 30'h0;
  end
endmodule // ivm_core_model
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the vector mapping top
// assumes the core model clears flags on request
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ck = 1'b0, rb = 1'b0, ge = 1'b0, sp = 1'b0, nm = 1'b0, sv = 1'b0, irq, nreq;
  logic [29:0] ev = 30'h0, en = 30'h0, clr, fl;
  logic [4:0] vec;
  logic [5:0] adr;
  int error_cnt = 0, n_compared = 0;
  initial forever #50 ck = ~ck;
  ivm_top uut (.MCLK_IN(ck), .RST_B_IN(rb), .GLOBAL_EN_IN(ge), .TIMER_A_SPLIT_IN(sp),
    .NMI_IN(nm), .EVENT_IN(ev), .CLEAR_IN(clr), .ENABLE_IN(en), .FLAGS_OUT(fl),
    .IRQ_OUT(irq), .NMI_REQ_OUT(nreq), .VECTOR_OUT(vec), .VEC_ADDR_OUT(adr));
  ivm_core_model core (.clk_in(ck), .serve_in(sv), .irq_in(irq), .vec_in(vec), .clear_out(clr));
  task automatic chk(input logic [29:0] e, input logic [29:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ck);
  endtask
  task automatic pulse(input int v);
    ev[v] = 1'b1;
    tick(1);
    ev = 30'h0;
  endtask
  task automatic wait_irq;
    for (int i = 0; i < 5 && irq !== 1'b1; i++) tick(1);
  endtask
  task automatic t_mask;
    ge = 1'b1;
    pulse(5);
    tick(3);
    chk(1, fl[5]);
    chk(0, irq);
    ge = 1'b0;
    en[5] = 1'b1;
    tick(3);
    chk(0, irq);
    ge = 1'b1;
    tick(8);
    chk(1, irq);
    sv = 1'b1;
    tick(4);
    chk(0, irq);
    sv = 1'b0;
  endtask
  task automatic t_split;
    en = '1;
    pulse(10);
    pulse(1);
    tick(3);
    chk(0, fl);
    nm = 1'b1;
    tick(3);
    chk(1, vec);
    chk(1, nreq);
    nm = 1'b0;
    tick(3);
    chk(0, irq);
  endtask
  task automatic t_map;
    sp = 1'b1;
    sv = 1'b1;
    for (int v = 2; v < 30; v++) begin
      pulse(v);
      wait_irq();
      chk(v, vec);
      chk(2 * v, adr);
      tick(4);
      chk(0, fl);
    end
  endtask
  task automatic t_prio;
    sv = 1'b0;
    ev[20] = 1'b1;
    ev[8] = 1'b1;
    tick(1);
    ev = 30'h0;
    tick(3);
    chk(8, vec);
    sv = 1'b1;
    tick(3);
    chk(20, vec);
    tick(4);
    chk(0, fl);
    sv = 1'b0;
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    tick(12);
    rb = 1'b1;
    tick(2);
    t_mask();
    t_split();
    t_map();
    t_prio();
    wrap_up();
  end
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
endmodule // testbench
bind ivm_top ivm_props props (.MCLK_IN(MCLK_IN), .RST_B_IN(RST_B_IN),
  .GLOBAL_EN_IN(GLOBAL_EN_IN), .TIMER_A_SPLIT_IN(TIMER_A_SPLIT_IN), .NMI_IN(NMI_IN),
  .EVENT_IN(EVENT_IN), .CLEAR_IN(CLEAR_IN), .ENABLE_IN(ENABLE_IN), .FLAGS_OUT(FLAGS_OUT),
  .IRQ_OUT(IRQ_OUT), .NMI_REQ_OUT(NMI_REQ_OUT), .VECTOR_OUT(VECTOR_OUT),
  .VEC_ADDR_OUT(VEC_ADDR_OUT));
`default_nettype wire
